// ### pkg/jtx_pkg.sv
// Shared constants, state type and position helpers for the transmit link
//
// Functional notes
// R1 - Low-byte frame-start flag marks a frame starting at bits 7:0 next word.
// R2 - High-byte frame-start flag marks a frame starting at bits 15:8 next word.
// R3 - Falling restart request returns control to CGS, then fresh CGS and ILAS.
// R4 - Alignment sequence length input is accepted; length behaves fixed at four.
// R5 - SYSREF marks multiframe start and anchors all transmit boundary timing.
// R6 - Converter SYNC request starts the initialization sequence.
// R7 - Transmit data to the lanes is 16 bits per lane.
// R8 - Two control-character bits per lane, one per octet.
// R9 - Frame clock derives from core clock divided by octets per frame; no frame clock is made here, only the frame boundary flags.
// R10 - User data arrives at two octets per lane every clock and is taken.
// R11 - Lane data is scrambled before framing unless the bypass option is set.
// R12 - Alignment, framing and configuration characters are inserted as needed.
// R13 - Control state machine selects user data or initialization content.
// R14 - External lane logic does 8b/10b encoding; this block never encodes.
// R15 - User places frame octets where the boundary flags say.
// R16 - With three octets per frame, last octet follows frame-end flag position.
// R17 - Active-low reset returns control logic and counters to initial states.
// R18 - Frame-end flags mark a frame ending at bits 7:0 or 15:8 next word.
// R19 - A 2-bit output reports the control block state.
package jtx_pkg;
   localparam int LANES         = 2;
   localparam int LANE_W        = 16;
   localparam int DATA_W        = LANES * LANE_W;
   localparam int K_W           = LANES * 2;
   localparam int OCT_PER_FRAME = 3;
   localparam int FRAMES_PER_MF = 32;
   localparam int OCT_PER_MF    = OCT_PER_FRAME * FRAMES_PER_MF;
   localparam int POS_W         = 7;
   localparam int ILAS_MF       = 4;
   localparam int MF_CYCLES     = OCT_PER_MF / 2;
   localparam int ILAS_CYCLES   = ILAS_MF * MF_CYCLES;
   localparam int SCR_W         = 15;
   localparam int CFG_FIRST     = 2;
   localparam int CFG_OCTETS    = 14;
   localparam int CONVERTERS    = 2;
   localparam int SAMPLE_BITS   = 16;
   localparam int SAMPLES       = 1;

   localparam logic [7:0] CHAR_R  = 8'h1C;
   localparam logic [7:0] CHAR_A  = 8'h7C;
   localparam logic [7:0] CHAR_Q  = 8'h9C;
   localparam logic [7:0] CHAR_K  = 8'hBC;
   localparam logic [7:0] CHAR_F  = 8'hFC;

   // Link identity; arbitrary values
   localparam logic [7:0] DEVICE_ID = 8'h5A;
   localparam logic [3:0] BANK_ID   = 4'h3;
   localparam logic [1:0] CTRL_BITS = 2'h0;
   localparam logic [2:0] SUBCLASS  = 3'h1;
   localparam logic [2:0] JESD_VER  = 3'h1;
   localparam logic       HIGH_DENS = 1'b0;
   localparam logic [4:0] CTRL_WRDS = 5'h00;

   localparam logic [SCR_W-1:0] SCR_SEED = 15'h0000;

   typedef enum logic [1:0] {
      ST_CGS  = 2'h0,
      ST_ILAS = 2'h1,
      ST_DATA = 2'h3
   } link_state_t;

   // Octet position inside its frame
   function automatic logic [1:0] frame_pos(input logic [POS_W-1:0] p);
      return 2'(p % 7'(OCT_PER_FRAME));
   endfunction

   // Octet position of the following lane word
   function automatic logic [POS_W-1:0] pos_adv(input logic [POS_W-1:0] p);
      if (p >= 7'(OCT_PER_MF - 2)) begin
         return 7'h00;
      end
      return 7'(p + 7'h02);
   endfunction
endpackage

// ### pkg/bnd_if.sv
// Boundary flags and word position between counter and control
`timescale 1ns/1ns
`default_nettype none
interface bnd_if;
   logic                      frm_start_l;
   logic                      frm_start_h;
   logic                      frm_end_l;
   logic                      frm_end_h;
   logic [jtx_pkg::POS_W-1:0] pos;

   modport src (output frm_start_l, frm_start_h, frm_end_l, frm_end_h, pos);
   modport dst (input  frm_start_l, frm_start_h, frm_end_l, frm_end_h, pos);
endinterface
`default_nettype wire

// ### src/jtx_scrambler.sv
// Per-lane self-synchronous scrambler with bypass
`timescale 1ns/1ns
`default_nettype none
module jtx_scrambler (
   input  wire logic                        i_clock,
   input  wire logic                        i_rstn,
   input  wire logic                        i_bypass,
   input  wire logic [jtx_pkg::DATA_W-1:0]  i_data,
   output logic      [jtx_pkg::DATA_W-1:0]  o_data
);
   typedef struct packed {
      logic [jtx_pkg::LANES-1:0][jtx_pkg::SCR_W-1:0] sr;
      logic [jtx_pkg::DATA_W-1:0]                    data;
   } scr_t;

   scr_t s_q;
   scr_t s_d;

   // Scrambles one lane word, low octet first, msb first
   function automatic logic [30:0] scr_word(input logic [14:0] sr,
                                            input logic [15:0] w);
      logic [14:0] s;
      logic [15:0] o;
      int          b;
      logic        x;
      s = sr;
      o = 16'h0000;
      for (int i = 0; i < 16; i++) begin
         b = (i < 8) ? 7 - i : 23 - i;
         x = w[b] ^ s[13] ^ s[14];
         o[b] = x;
         s = {s[13:0], x};
      end
      return {s, o};
   endfunction

   always_comb begin
      logic [30:0] r;
      r = 31'h00000000;
      s_d = s_q;
      for (int l = 0; l < jtx_pkg::LANES; l++) begin
         r = scr_word(s_q.sr[l], i_data[l*16 +: 16]);
         s_d.sr[l] = r[30:16];
         s_d.data[l*16 +: 16] = i_bypass ? i_data[l*16 +: 16] : r[15:0]; // [R11] [R10]
      end
   end

   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         s_q <= '{sr: {jtx_pkg::LANES{jtx_pkg::SCR_SEED}}, data: '0}; // [R17]
      end else begin
         s_q <= s_d;
      end
   end

   assign o_data = s_q.data;

   bypass_pass_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R11]
      i_bypass |=> (o_data == $past(i_data)))
      else $error("bypass did not pass data unchanged");
endmodule
`default_nettype wire

// ### src/jtx_boundary.sv
// Multiframe octet counter anchored on sysref, with boundary flags
`timescale 1ns/1ns
`default_nettype none
module jtx_boundary (
   input  wire logic i_clock,
   input  wire logic i_rstn,
   input  wire logic i_sysref,
   bnd_if.src        bnd
);
   typedef struct packed {
      logic                      sr_m;
      logic                      sr_s;
      logic                      sr_p;
      logic [jtx_pkg::POS_W-1:0] pos;
      logic                      fsl;
      logic                      fsh;
      logic                      fel;
      logic                      feh;
   } bnd_t;

   bnd_t                      s_q;
   bnd_t                      s_d;
   logic                      rise;
   logic [jtx_pkg::POS_W-1:0] np;

   always_comb begin
      s_d = s_q;
      s_d.sr_m = i_sysref;
      s_d.sr_s = s_q.sr_m;
      s_d.sr_p = s_q.sr_s;
      rise = s_q.sr_s & ~s_q.sr_p;
      s_d.pos = rise ? 7'h00 : jtx_pkg::pos_adv(s_q.pos); // [R5]
      np = jtx_pkg::pos_adv(s_d.pos);
      s_d.fsl = jtx_pkg::frame_pos(np) == 2'h0; // [R1]
      s_d.fsh = jtx_pkg::frame_pos(7'(np + 7'h01)) == 2'h0; // [R2]
      s_d.fel = jtx_pkg::frame_pos(np) == 2'(jtx_pkg::OCT_PER_FRAME - 1); // [R18]
      s_d.feh = jtx_pkg::frame_pos(7'(np + 7'h01)) ==
                2'(jtx_pkg::OCT_PER_FRAME - 1); // [R18]
   end

   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         s_q <= '0; // [R17]
      end else begin
         s_q <= s_d;
      end
   end

   assign bnd.frm_start_l = s_q.fsl;
   assign bnd.frm_start_h = s_q.fsh;
   assign bnd.frm_end_l   = s_q.fel;
   assign bnd.frm_end_h   = s_q.feh;
   assign bnd.pos         = s_q.pos;

   start_low_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R1]
      (s_q.fsl && !rise) |=> (jtx_pkg::frame_pos(s_q.pos) == 2'h0))
      else $error("low frame start flag misplaced");
   start_high_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R2]
      (s_q.fsh && !rise) |=> (jtx_pkg::frame_pos(s_q.pos) == 2'h2))
      else $error("high frame start flag misplaced");
   end_flags_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R18]
      (!rise && (s_q.fel || s_q.feh)) |=>
         (jtx_pkg::frame_pos(s_q.pos) == ($past(s_q.fel) ? 2'h2 : 2'h1)))
      else $error("frame end flag misplaced");
   sysref_align_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R5]
      rise |=> (s_q.pos == 7'h00) ##1 (s_q.pos == 7'h02))
      else $error("sysref did not restart multiframe");
endmodule
`default_nettype wire

// ### src/jtx_link_tx.sv
// Transmit link layer top: sync, control state machine and lane framing
`timescale 1ns/1ns
`default_nettype none
module jtx_link_tx (
   input  wire logic                        i_clock,
   input  wire logic                        i_rstn,
   input  wire logic [jtx_pkg::DATA_W-1:0]  i_user_data,
   input  wire logic                        i_scramble_off,
   input  wire logic                        i_restart_request_low,
   input  wire logic [7:0]                  i_alignment_sequence_length,
   input  wire logic                        i_sysref,
   input  wire logic                        i_sync_n,
   output logic      [jtx_pkg::DATA_W-1:0]  o_tx_data,
   output logic      [jtx_pkg::K_W-1:0]     o_tx_k,
   output logic                             o_frm_start_l,
   output logic                             o_frm_start_h,
   output logic                             o_frm_end_l,
   output logic                             o_frm_end_h,
   output logic      [1:0]                  o_state
);
   typedef struct packed {
      logic                       sync_m;
      logic                       sync_s;
      logic                       rr_m;
      logic                       rr_s;
      logic                       rr_p;
      jtx_pkg::link_state_t       state;
      logic [1:0]                 ilas_mf;
      logic [jtx_pkg::POS_W-1:0]  p_pos;
      logic [jtx_pkg::DATA_W-1:0] tx_data;
      logic [jtx_pkg::K_W-1:0]    tx_k;
   } ctl_t;

   localparam ctl_t CTL_RESET = '{
      sync_m:  1'b0,
      sync_s:  1'b0,
      rr_m:    1'b1,
      rr_s:    1'b1,
      rr_p:    1'b1,
      state:   jtx_pkg::ST_CGS,
      ilas_mf: 2'h0,
      p_pos:   7'h00,
      tx_data: '0,
      tx_k:    '0
   };

   ctl_t                       s_q;
   ctl_t                       s_d;
   logic [jtx_pkg::DATA_W-1:0] scr_data;
   logic                       rr_fall;
   logic                       mf_end;
   logic                       scr_on;
   logic [11:0]                ilas_cyc;

   bnd_if bnd ();

   // The sequence length input is taken but the length stays at four
   jtx_boundary u_boundary (
      .i_clock  (i_clock),
      .i_rstn   (i_rstn),
      .i_sysref (i_sysref),
      .bnd      (bnd)
   );

   jtx_scrambler u_scrambler (
      .i_clock  (i_clock),
      .i_rstn   (i_rstn),
      .i_bypass (i_scramble_off),
      .i_data   (i_user_data),
      .o_data   (scr_data)
   );

   // One configuration octet of the second alignment multiframe
   function automatic logic [7:0] cfg_octet(input logic [3:0] idx,
                                            input logic [7:0] lane,
                                            input logic       scr);
      case (idx)
         4'h0:    return jtx_pkg::DEVICE_ID;
         4'h1:    return {4'h0, jtx_pkg::BANK_ID};
         4'h2:    return {3'h0, lane[4:0]};
         4'h3:    return {scr, 2'h0, 5'(jtx_pkg::LANES - 1)};
         4'h4:    return 8'(jtx_pkg::OCT_PER_FRAME - 1);
         4'h5:    return {3'h0, 5'(jtx_pkg::FRAMES_PER_MF - 1)};
         4'h6:    return 8'(jtx_pkg::CONVERTERS - 1);
         4'h7:    return {jtx_pkg::CTRL_BITS, 1'b0,
                          5'(jtx_pkg::SAMPLE_BITS - 1)};
         4'h8:    return {jtx_pkg::SUBCLASS, 5'(jtx_pkg::SAMPLE_BITS - 1)};
         4'h9:    return {jtx_pkg::JESD_VER, 5'(jtx_pkg::SAMPLES - 1)};
         4'hA:    return {jtx_pkg::HIGH_DENS, 2'h0, jtx_pkg::CTRL_WRDS};
         default: return 8'h00;
      endcase
   endfunction

   // Checksum over the configuration octets before it
   function automatic logic [7:0] cfg_check(input logic [7:0] lane,
                                            input logic       scr);
      logic [7:0] sum;
      sum = 8'h00;
      for (int i = 0; i < jtx_pkg::CFG_OCTETS - 1; i++) begin
         sum = 8'(sum + cfg_octet(4'(i), lane, scr));
      end
      return sum;
   endfunction

   // One output octet with its control-character bit
   function automatic logic [8:0] build_octet(
      input jtx_pkg::link_state_t  st,
      input logic [1:0]            mf,
      input logic [6:0]            o,
      input logic [7:0]            lane,
      input logic [7:0]            user,
      input logic                  scr);
      logic [3:0] ci;
      logic       f_end;
      logic       m_end;
      ci = 4'(o - 7'(jtx_pkg::CFG_FIRST));
      f_end = jtx_pkg::frame_pos(o) == 2'(jtx_pkg::OCT_PER_FRAME - 1);
      m_end = o == 7'(jtx_pkg::OCT_PER_MF - 1);
      case (st)
         jtx_pkg::ST_CGS: begin
            return {1'b1, jtx_pkg::CHAR_K}; // [R12]
         end
         jtx_pkg::ST_ILAS: begin
            if (o == 7'h00) begin
               return {1'b1, jtx_pkg::CHAR_R}; // [R12]
            end
            if (m_end) begin
               return {1'b1, jtx_pkg::CHAR_A}; // [R12]
            end
            if (mf == 2'h1 && o == 7'h01) begin
               return {1'b1, jtx_pkg::CHAR_Q}; // [R12]
            end
            if (mf == 2'h1 && o >= 7'(jtx_pkg::CFG_FIRST) &&
                o < 7'(jtx_pkg::CFG_FIRST + jtx_pkg::CFG_OCTETS)) begin
               if (ci == 4'(jtx_pkg::CFG_OCTETS - 1)) begin
                  return {1'b0, cfg_check(lane, scr)}; // [R12]
               end
               return {1'b0, cfg_octet(ci, lane, scr)}; // [R12]
            end
            return {1'b0, 1'b0, o};
         end
         jtx_pkg::ST_DATA: begin
            // Scrambled end octets that match a marker are sent as markers
            if (scr && m_end && user == jtx_pkg::CHAR_A) begin
               return {1'b1, user}; // [R12]
            end
            if (scr && f_end && user == jtx_pkg::CHAR_F) begin
               return {1'b1, user}; // [R12]
            end
            return {1'b0, user}; // [R13]
         end
         default: begin
            return {1'b1, jtx_pkg::CHAR_K};
         end
      endcase
   endfunction

   always_comb begin
      logic [8:0] lo;
      logic [8:0] hi;
      lo = 9'h000;
      hi = 9'h000;
      s_d = s_q;
      scr_on = ~i_scramble_off;
      s_d.sync_m = i_sync_n;
      s_d.sync_s = s_q.sync_m;
      s_d.rr_m = i_restart_request_low;
      s_d.rr_s = s_q.rr_m;
      s_d.rr_p = s_q.rr_s;
      rr_fall = s_q.rr_p & ~s_q.rr_s; // [R3]
      mf_end = s_q.p_pos == 7'(jtx_pkg::OCT_PER_MF - 2);
      s_d.p_pos = bnd.pos;

      case (s_q.state)
         jtx_pkg::ST_CGS: begin
            if (s_q.sync_s && mf_end) begin
               s_d.state = jtx_pkg::ST_ILAS; // [R6] [R5]
               s_d.ilas_mf = 2'h0;
            end
         end
         jtx_pkg::ST_ILAS: begin
            if (mf_end) begin
               if (s_q.ilas_mf == 2'(jtx_pkg::ILAS_MF - 1)) begin
                  s_d.state = jtx_pkg::ST_DATA; // [R4]
               end else begin
                  s_d.ilas_mf = 2'(s_q.ilas_mf + 2'h1); // [R4]
               end
            end
         end
         jtx_pkg::ST_DATA: begin
            s_d.state = jtx_pkg::ST_DATA;
         end
         default: begin
            s_d.state = jtx_pkg::ST_CGS;
         end
      endcase

      if (!s_q.sync_s || rr_fall) begin
         s_d.state = jtx_pkg::ST_CGS; // [R3] [R6]
         s_d.ilas_mf = 2'h0;
      end

      for (int l = 0; l < jtx_pkg::LANES; l++) begin
         lo = build_octet(s_q.state, s_q.ilas_mf, s_q.p_pos, 8'(l),
                          scr_data[l*16 +: 8], scr_on); // [R13]
         hi = build_octet(s_q.state, s_q.ilas_mf, 7'(s_q.p_pos + 7'h01),
                          8'(l), scr_data[l*16+8 +: 8], scr_on); // [R13]
         s_d.tx_data[l*16 +: 16] = {hi[7:0], lo[7:0]}; // [R7]
         s_d.tx_k[l*2 +: 2] = {hi[8], lo[8]}; // [R8]
      end
   end

   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         s_q <= CTL_RESET; // [R17]
      end else begin
         s_q <= s_d;
      end
   end

   assign o_tx_data     = s_q.tx_data;
   assign o_tx_k        = s_q.tx_k;
   assign o_state       = s_q.state; // [R19]
   assign o_frm_start_l = bnd.frm_start_l;
   assign o_frm_start_h = bnd.frm_start_h;
   assign o_frm_end_l   = bnd.frm_end_l;
   assign o_frm_end_h   = bnd.frm_end_h;

   // Cycles spent in the alignment state
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         ilas_cyc <= 12'h000;
      end else if (s_q.state == jtx_pkg::ST_ILAS) begin
         ilas_cyc <= 12'(ilas_cyc + 12'h001);
      end else begin
         ilas_cyc <= 12'h000;
      end
   end

   restart_cgs_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R3]
      (s_q.rr_p && !s_q.rr_s) |=> (o_state == jtx_pkg::ST_CGS))
      else $error("restart request did not force CGS");

   sync_cgs_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R6]
      (!s_q.sync_s) |=> (o_state == jtx_pkg::ST_CGS) ##1
         (o_tx_k == {jtx_pkg::K_W{1'b1}}))
      else $error("sync request did not hold CGS");

   cgs_fill_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R12]
      (s_q.state == jtx_pkg::ST_CGS) |=>
         (o_tx_data == {(2 * jtx_pkg::LANES){jtx_pkg::CHAR_K}}))
      else $error("CGS characters missing");

   ilas_start_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R12]
      (s_q.state == jtx_pkg::ST_ILAS && s_q.p_pos == 7'h00) |=>
         (o_tx_data[7:0] == jtx_pkg::CHAR_R && o_tx_k[0]))
      else $error("multiframe start marker missing");

   ilas_len_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R4]
      (s_q.state == jtx_pkg::ST_ILAS && s_d.state == jtx_pkg::ST_DATA) |->
         (ilas_cyc == 12'(jtx_pkg::ILAS_CYCLES - 1)))
      else $error("alignment sequence is not four multiframes");

   data_pass_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // [R13]
      (s_q.state == jtx_pkg::ST_DATA &&
       jtx_pkg::frame_pos(s_q.p_pos) != 2'h2) |=>
         (o_tx_data[7:0] == $past(scr_data[7:0]) && !o_tx_k[0]))
      else $error("user data not forwarded in data state");
endmodule
`default_nettype wire

// ### tb/jtx_dac_model.sv
// Converter-side partner: holds sync low until nine CGS words have arrived, not necessarily in a row
`timescale 1ns/1ns
`default_nettype none
module jtx_dac_model (
   input  wire logic                       i_clock,
   input  wire logic                       i_rstn,
   input  wire logic [jtx_pkg::DATA_W-1:0] i_tx_data,
   input  wire logic [jtx_pkg::K_W-1:0]    i_tx_k,
   input  wire logic                       i_resync,
   output logic                            o_sync_n
);
   logic [3:0] cgs_cnt;

   // Whole octets with k bits; no 10b decode here
   always @(negedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         cgs_cnt  <= 4'h0;
         o_sync_n <= 1'b0;
      end else if (i_resync) begin
         cgs_cnt  <= 4'h0;
         o_sync_n <= 1'b0;
      end else if (i_tx_k === '1 && i_tx_data === {4{8'hBC}}) begin
         if (cgs_cnt == 4'h8) begin
            o_sync_n <= 1'b1;
         end else begin
            cgs_cnt <= cgs_cnt + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ### tb/jesd204b_tx_link_layer_tb.sv
// Self-checking bench for the transmit link layer
`timescale 1ns/1ns
`default_nettype none
module jesd204b_tx_link_layer_tb;
   localparam int PAT = jtx_pkg::OCT_PER_FRAME; // Two frames per F clocks
   logic        clock       = 1'b0;
   logic        rstn        = 1'b0;
   logic [31:0] user_data   = '0;
   logic        scr_off     = 1'b1;
   logic        restart_low = 1'b1;
   logic        sysref      = 1'b0;
   logic        resync      = 1'b0;
   logic [7:0]  ila_len     = 8'h10;
   logic        sync_n;
   logic [31:0] tx_data;
   logic [3:0]  tx_k;
   logic        fsl, fsh, fel, feh;
   logic [1:0]  state;
   logic [14:0] ds [2];
   logic [3:0]  pat [PAT] = '{4'b1000, 4'b0110, 4'b0001};
   int          n_mismatch  = 0;
   int          n_compared  = 0;

   always #2 clock = ~clock;

   jtx_link_tx dut (
      .i_clock                     (clock),
      .i_rstn                      (rstn),
      .i_user_data                 (user_data),
      .i_scramble_off              (scr_off),
      .i_restart_request_low       (restart_low),
      .i_alignment_sequence_length (ila_len),
      .i_sysref                    (sysref),
      .i_sync_n                    (sync_n),
      .o_tx_data                   (tx_data),
      .o_tx_k                      (tx_k),
      .o_frm_start_l               (fsl),
      .o_frm_start_h               (fsh),
      .o_frm_end_l                 (fel),
      .o_frm_end_h                 (feh),
      .o_state                     (state)
   );

   jtx_dac_model partner (
      .i_clock   (clock),
      .i_rstn    (rstn),
      .i_tx_data (tx_data),
      .i_tx_k    (tx_k),
      .i_resync  (resync),
      .o_sync_n  (sync_n)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string msg);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t %s: got %h exp %h", $time, msg, seen, exp);
      end
   endtask

   task automatic stop_test;
      $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic wait_state(input logic [1:0] st, input string msg);
      int i;
      i = 0;
      while (state !== st && i < 400) begin
         @(negedge clock);
         i++;
      end
      check({30'h0, state}, {30'h0, st}, msg);
   endtask

   // Octet index per lane word position, placed as flags direct
   function automatic logic [31:0] uword(input int i);
      return {8'(4 * i + 3), 8'(4 * i + 2), 8'(4 * i + 1), 8'(4 * i)};
   endfunction

   task automatic descr(input int l, input logic [15:0] w,
                        output logic [15:0] d);
      int   b;
      logic x;
      for (b = 0; b < 16; b++) begin
         x = w[b < 8 ? 7 - b : 23 - b];
         d[b < 8 ? 7 - b : 23 - b] = x ^ ds[l][13] ^ ds[l][14];
         ds[l] = {ds[l][13:0], x};
      end
   endtask

   task automatic t_reset;
      rstn = 1'b0;
      repeat (16) @(negedge clock);
      check(tx_data, '0, "data in reset");
      check({28'h0, tx_k, fsl, fsh, fel, feh}, '0, "k, flags");
      check({30'h0, state}, '0, "state in reset");
      rstn = 1'b1;
      repeat (3) @(negedge clock);
      check(tx_data, {4{8'hBC}}, "CGS data");
      check({28'h0, tx_k}, 32'hF, "CGS k");
      $display("t_reset done");
   endtask

   task automatic t_ilas;
      int   n;
      int   n_a;
      logic r_seen;
      wait_state(2'h1, "enter ILAS");
      n = 0;
      n_a = 0;
      r_seen = 1'b0;
      while (state === 2'h1 && n < 300) begin
         if (tx_k[0] === 1'b1 && tx_data[7:0] === jtx_pkg::CHAR_R) begin
            r_seen = 1'b1;
         end
         if (tx_k[1] === 1'b1 && tx_data[15:8] === jtx_pkg::CHAR_A) begin
            n_a++;
         end
         @(negedge clock);
         n++;
      end
      // Output word lags the state by one cycle
      if (tx_k[1] === 1'b1 && tx_data[15:8] === jtx_pkg::CHAR_A) begin
         n_a++;
      end
      check(32'(n), jtx_pkg::ILAS_CYCLES, "ILAS length");
      check(32'(n_a), 32'(jtx_pkg::ILAS_MF), "A chars");
      check({31'h0, r_seen}, 32'h1, "R char");
      check({30'h0, state}, 32'h3, "DATA state");
      $display("t_ilas done");
   endtask

   task automatic flag_run(output int k);
      int i;
      sysref = 1'b1;
      @(negedge clock);
      sysref = 1'b0;
      repeat (10) @(negedge clock);
      k = PAT;
      for (i = 0; i < PAT; i++) begin
         if ({fsl, fsh, fel, feh} === pat[i]) begin
            k = i;
         end
      end
      for (i = 0; i < 12; i++) begin
         check({fsl, fsh, fel, feh}, pat[(k + i) % PAT], "flags");
         @(negedge clock);
      end
   endtask

   task automatic t_flags;
      int k1, k2;
      flag_run(k1);
      repeat (8) @(negedge clock);
      flag_run(k2);
      check(32'(k2), 32'(k1), "sysref anchor");
      $display("t_flags done");
   endtask

   task automatic t_data(input logic off);
      int          i, l, diffs;
      logic [15:0] d;
      logic [31:0] exp;
      scr_off = off;
      diffs = 0;
      for (i = 0; i < 24; i++) begin
         exp = uword(i - 2);
         for (l = 0; l < 2 && i >= 3; l++) begin
            descr(l, tx_data[l*16 +: 16], d);
            if (d !== tx_data[l*16 +: 16]) begin
               diffs++;
            end
            if (i >= 6 && off) begin
               check(tx_data, exp, "bypass data");
               check({28'h0, tx_k}, '0, "data k");
            end else if (i >= 6) begin
               check({16'h0, d}, {16'h0, exp[l*16 +: 16]}, "descr");
            end
         end
         user_data = uword(i);
         @(negedge clock);
      end
      if (!off) begin
         check({31'h0, diffs > 0}, 32'h1, "scrambled");
      end
      $display("t_data done");
   endtask

   task automatic t_restart;
      int n;
      restart_low = 1'b0;
      wait_state(2'h0, "restart CGS");
      n = 0;
      while (tx_data !== {4{8'hBC}} && n < 6) begin
         @(negedge clock);
         n++;
      end
      check(tx_data, {4{8'hBC}}, "restart K28.5");
      restart_low = 1'b1;
      t_ilas();
      $display("t_restart done");
   endtask

   task automatic t_sync;
      resync = 1'b1;
      repeat (2) @(negedge clock);
      wait_state(2'h0, "sync CGS");
      resync = 1'b0;
      ila_len = 8'hFF;
      t_ilas();
      $display("t_sync done");
   endtask

   initial begin
      @(negedge clock);
      t_reset();
      t_ilas();
      t_flags();
      t_data(1'b1);
      t_data(1'b0);
      t_restart();
      t_sync();
      stop_test();
   end

   initial begin
      #40000;
      n_mismatch++;
      $display("[ERR] %0t watchdog expired", $time);
      stop_test();
   end
endmodule
`default_nettype wire
